/* File: pxe_asserts.sv */
// Purpose: Port-level checks for the port expander target
// Assumes: Sees only the top module ports, one clock domain
// Notes:   Bound into pxe_top at the foot of this file
`timescale 1ns/1ps
module pxe_asserts (
    // Clock and reset
    input wire       clk,
    input wire       srst,
    // Bus lines
    input wire       scl_in,
    input wire       sda_in,
    input wire       sda_out_q,
    input wire       sda_oe_q,
    // Address straps
    input wire       addr_strap_bit2,
    input wire       addr_strap_bit1,
    input wire       addr_strap_bit0,
    // Port lines and interrupt
    input wire [7:0] low_port_in,
    input wire [7:0] high_port_in,
    input wire [7:0] low_port_lines_q,
    input wire [7:0] high_port_lines_q,
    input wire       int_n_q
);
    wire [15:0] pins = {high_port_in, low_port_in};          // Pin levels
    wire [15:0] outs = {high_port_lines_q, low_port_lines_q}; // Latches
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ********************************************
    // Sequences
    // ********************************************
    sequence s_scl_high;
        scl_in [*4];
    endsequence
    sequence s_pins_still;
        $stable(pins) [*8];
    endsequence
    // ********************************************
    // Properties
    // ********************************************
    property p_rst;
        $fell(srst) |-> outs == 16'hffff && int_n_q && !sda_oe_q;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_od;
        sda_out_q == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("sda drives high");
    // Ack must not move while the clock is high
    property p_ack_hold;
        s_scl_high |-> $stable(sda_oe_q);
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("sda moved");
    property p_ack_len;
        $rose(sda_oe_q) |-> sda_oe_q [*5];
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack short");
    property p_port_upd;
        $changed(outs) |-> !scl_in;
    endproperty
    a_port_upd: assert property (p_port_upd) else $error("late port");
    property p_int_quiet;
        s_pins_still ##0 int_n_q |=> int_n_q;
    endproperty
    a_int_quiet: assert property (p_int_quiet) else $error("stray int");
    property p_int_fall;
        $fell(int_n_q) |-> $past(pins, 2) != $past(pins, 6);
    endproperty
    a_int_fall: assert property (p_int_fall) else $error("int cause");
    // A start seen on the wire is never of the target's making
    property p_start_free;
        $fell(sda_in) && $past(scl_in, 2) && scl_in |-> !sda_oe_q;
    endproperty
    a_start_free: assert property (p_start_free) else $error("fake");
endmodule // pxe_asserts

bind pxe_top pxe_asserts u_chk (
    .clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
    .addr_strap_bit2(addr_strap_bit2), .addr_strap_bit1(addr_strap_bit1),
    .addr_strap_bit0(addr_strap_bit0), .low_port_in(low_port_in),
    .high_port_in(high_port_in), .low_port_lines_q(low_port_lines_q),
    .high_port_lines_q(high_port_lines_q), .int_n_q(int_n_q));

/* File: pxe_defines.vh */
// Purpose: Constants for the sixteen-bit I2C port expander target
// Assumes: Included by pxe_top.v only
// Notes:   Definitions only
`ifndef PXE_DEFINES_VH
`define PXE_DEFINES_VH

// ********************************************
// Address byte layout and port reset value
// ********************************************
`define PXE_ADDR_FIXED      4'h4        // Fixed upper nibble 0100
`define PXE_PORT_RESET      16'hffff    // All port lines high after reset

// ********************************************
// Bit machine states
// ********************************************
`define PXE_ST_IDLE         3'h0
`define PXE_ST_ADDR         3'h1
`define PXE_ST_AACK         3'h2
`define PXE_ST_WDATA        3'h3
`define PXE_ST_WACK         3'h4
`define PXE_ST_RDATA        3'h5
`define PXE_ST_RACK         3'h6

`endif

/* File: pxe_master.sv */
// Purpose: Behavioural bus controller facing the expander
// Assumes: Clock period 160 ns, four system clocks per half
// Notes:   Clock stands high between frames; sda has a pull-up
`timescale 1ns/1ps
module pxe_master (
    // Clock
    input wire clk,
    // Bus
    input wire sda_oe_q,
    output reg scl,
    output wire sda
);
    reg sda_m = 1'b1;                 // Own drive, 1 means released
    initial scl = 1'b1;               // Idle bus stands high
    assign sda = sda_m & ~sda_oe_q;   // Pull-up wins when nobody pulls
    task q;
        repeat (2) @(posedge clk);
    endtask
    // Also serves as a repeated start
    task start;
        sda_m <= 1'b1;
        q;
        scl <= 1'b1;
        q;
        sda_m <= 1'b0;
        q;
        scl <= 1'b0;
    endtask
    // Data changes mid-low, sampled just before the fall
    task bit_io(input b, output r);
        q;
        sda_m <= b;
        q;
        scl <= 1'b1;
        q;
        q;
        r = sda;
        scl <= 1'b0;
    endtask
    task xfer(input [7:0] d, input ak, output [7:0] r, output k);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
            bit_io(d[i], r[i]);
        bit_io(ak, k);
    endtask
    task stop;
        q;
        sda_m <= 1'b0;
        q;
        scl <= 1'b1;
        q;
        sda_m <= 1'b1;
        q;
    endtask
endmodule // pxe_master

/* File: pxe_tb.sv */
// Purpose: Self-checking bench for the port expander target
// Assumes: pxe_master plays the bus controller
// Notes:   Port pins are driven straight by the bench
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module pxe_tb;
    reg        clk    = 1'b0;
    reg        srst   = 1'b1;
    reg  [2:0] strap  = 3'h0;
    reg  [7:0] pin_lo = 8'hff;
    reg  [7:0] pin_hi = 8'hff; // Idle lines held high as outputs
    wire       scl, sda, oe, int_n;
    wire [7:0] lo, hi;
    integer    fails   = 0;
    integer    checked = 0;
    always #10 clk = ~clk;
    pxe_master m (.clk(clk), .sda_oe_q(oe), .scl(scl), .sda(sda));
    pxe_top uut (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
        .sda_out_q(), .sda_oe_q(oe), .addr_strap_bit2(strap[2]),
        .addr_strap_bit1(strap[1]), .addr_strap_bit0(strap[0]),
        .low_port_in(pin_lo), .high_port_in(pin_hi),
        .low_port_lines_q(lo), .high_port_lines_q(hi), .int_n_q(int_n));
    // Write frame; every byte must see the expected ack level
    task wr(input [7:0] a, input [23:0] d, input integer n, input ea);
        reg [7:0] r;
        reg       k;
        integer   i;
        m.start;
        m.xfer(a, 1'b1, r, k);
        `CHK(k, ea)
        for (i = 0; i < n; i++) begin
            m.xfer(d[23 - 8 * i -: 8], 1'b1, r, k);
            `CHK(k, ea)
        end
        m.stop;
        repeat (4) @(posedge clk);
    endtask
    // Read one pair, master nacks the second byte
    task rd(input [7:0] a, output [15:0] v);
        reg k;
        m.start;
        m.xfer(a, 1'b1, v[7:0], k);
        `CHK(k, 1'b0)
        m.xfer(8'hff, 1'b0, v[7:0], k);
        m.xfer(8'hff, 1'b1, v[15:8], k);
        m.stop;
        repeat (4) @(posedge clk);
    endtask
    task t_reset;
        `CHK({hi, lo}, 16'hffff)
        `CHK({int_n, oe}, 2'b10)
    endtask
    // Each strap setting answers its own write address
    task t_addr;
        integer s;
        for (s = 0; s < 8; s++) begin
            strap <= s[2:0];
            repeat (4) @(posedge clk);
            wr({4'h4, s[2:0], 1'b0},
               {8'ha5 ^ s[7:0], 8'h3c + s[7:0], 8'h00}, 2, 1'b0);
            `CHK({hi, lo}, {8'h3c + s[7:0], 8'ha5 ^ s[7:0]})
        end
    endtask
    // Foreign addresses must leave the ports alone
    task t_refuse;
        strap <= 3'h5;
        repeat (4) @(posedge clk);
        wr(8'h00, 24'h12_3400, 2, 1'b1);
        wr(8'h44, 24'h12_3400, 2, 1'b1);
        wr(8'h5a, 24'h12_3400, 2, 1'b1);
        `CHK({hi, lo}, 16'h43a2)
    endtask
    // A lone trailing byte never reaches the ports
    task t_odd;
        wr(8'h4a, 24'h11_2233, 3, 1'b0);
        `CHK({hi, lo}, 16'h2211)
    endtask
    // Pin edges raise the interrupt; a return or a read clears it
    task t_read;
        reg [15:0] v;
        pin_lo <= 8'h5b;
        repeat (10) @(posedge clk);
        `CHK(int_n, 1'b0)
        pin_lo <= 8'hff;
        repeat (10) @(posedge clk);
        `CHK(int_n, 1'b1)
        pin_lo <= 8'h5a;
        pin_hi <= 8'hc3;
        repeat (10) @(posedge clk);
        `CHK(int_n, 1'b0)
        rd(8'h4b, v);
        `CHK(v, 16'hc35a)
        `CHK(int_n, 1'b1)
    endtask
    task test_done;
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        t_reset;
        t_addr;
        t_refuse;
        t_odd;
        t_read;
        test_done;
    end
    // Run needs about 64 us; cut a hang well past that
    initial begin
        #400000;
        fails++;
        test_done;
    end
endmodule // pxe_tb

/* File: pxe_top.v */
// Purpose: I2C target driving a sixteen-bit quasi-bidirectional port
// Assumes: clk is much faster than scl; scl, sda, straps, ports async
// Notes:   Bus lines are oversampled; scl edges found from synced copy
`timescale 1ns/1ps
`include "pxe_defines.vh"

// Overview of operation
// [R1] Address MSB first: 0100, straps, direction
// [R2] Answer 0x40-0x4E write, 0x41-0x4F read
// [R3] Data moves in whole low/high byte pairs
// [R4] Reset sets ports high, machine idle
// [R5] Only power-on reset; no command reset
// [R6] Controller sets unused lines as outputs
// [R7] First byte low port, second high port
// [R8] Ignore general call; ack by pulling sda
// [R9] Input edge asserts interrupt; access clears
// [R10] Mismatched address: release sda, ignore frame
module pxe_top (
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // I2C bus
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out_q,
    output reg         sda_oe_q,
    // Address straps
    input  wire        addr_strap_bit2,
    input  wire        addr_strap_bit1,
    input  wire        addr_strap_bit0,
    // Port lines (quasi-bidirectional: out 1 means weak high)
    input  wire [7:0]  low_port_in,
    input  wire [7:0]  high_port_in,
    output reg  [7:0]  low_port_lines_q,
    output reg  [7:0]  high_port_lines_q,
    // Interrupt, active low
    output reg         int_n_q
);

    // ********************************************
    // Input synchronisers
    // ********************************************
    reg  [1:0]  scl_s_q;        // scl two-stage
    reg  [1:0]  sda_s_q;        // sda two-stage
    reg  [2:0]  strap_m_q;      // Strap first stage
    reg  [2:0]  strap_q;        // Strap second stage
    reg  [15:0] pin_m_q;        // Port first stage
    reg  [15:0] pin_q;          // Port second stage
    reg         scl_d1_q;       // Previous synced scl
    reg         sda_d1_q;       // Previous synced sda

    // Two flops before any logic reads a pin
    always @(posedge clk) begin
        if (srst) begin
            scl_s_q   <= 2'b11;
            sda_s_q   <= 2'b11;
            strap_m_q <= 3'h0;
            strap_q   <= 3'h0;
            pin_m_q   <= `PXE_PORT_RESET;
            pin_q     <= `PXE_PORT_RESET;
            scl_d1_q  <= 1'b1;
            sda_d1_q  <= 1'b1;
        end else begin
            scl_s_q   <= {scl_s_q[0], scl_in};
            sda_s_q   <= {sda_s_q[0], sda_in};
            strap_m_q <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
            strap_q   <= strap_m_q;
            pin_m_q   <= {high_port_in, low_port_in};
            pin_q     <= pin_m_q;
            scl_d1_q  <= scl_s_q[1];
            sda_d1_q  <= sda_s_q[1];
        end
    end

    // Edge and condition decode, all from second stages
    wire scl_rise  = scl_s_q[1] & ~scl_d1_q;
    wire scl_fall  = ~scl_s_q[1] & scl_d1_q;
    wire start_det = scl_s_q[1] & scl_d1_q & ~sda_s_q[1] & sda_d1_q;
    wire stop_det  = scl_s_q[1] & scl_d1_q & sda_s_q[1] & ~sda_d1_q;

    // ********************************************
    // Bit machine
    // ********************************************
    reg  [2:0]  state_q;        // Current state
    reg  [3:0]  bit_cnt_q;      // Bits received or sent in this byte
    reg  [7:0]  shift_q;        // Shift register
    reg         pair_hi_q;      // Next byte belongs to high port
    reg  [7:0]  low_hold_q;     // First byte of pair waiting
    reg  [15:0] snap_q;         // Port sample for a read pair
    reg         clr_int_q;      // One-cycle interrupt clear pulse

    // Address match: fixed nibble plus straps; general call never matches
    function addr_hit;
        input [6:0] a;
        input [2:0] s;
        begin
            addr_hit = (a == {`PXE_ADDR_FIXED, s}); // [R1] [R2] [R8]
        end
    endfunction

    // Bit engine; samples on scl rise, drives sda after scl fall
    always @(posedge clk) begin
        if (srst) begin // [R4] [R5]
            state_q           <= `PXE_ST_IDLE;
            bit_cnt_q         <= 4'h0;
            shift_q           <= 8'h00;
            pair_hi_q         <= 1'b0;
            low_hold_q        <= 8'h00;
            snap_q            <= `PXE_PORT_RESET;
            sda_out_q         <= 1'b0;
            sda_oe_q          <= 1'b0;
            low_port_lines_q  <= 8'hff;
            high_port_lines_q <= 8'hff;
            clr_int_q         <= 1'b0;
        end else begin
            clr_int_q <= 1'b0;
            sda_out_q <= 1'b0;
            if (start_det) begin
                // Start or repeated start: restart address phase
                state_q   <= `PXE_ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_q  <= 1'b0;
            end else if (stop_det) begin
                // Stop: drop any half pair
                state_q  <= `PXE_ST_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                case (state_q)
                    `PXE_ST_ADDR: begin
                        if (scl_rise) begin // [R1]
                            shift_q   <= {shift_q[6:0], sda_s_q[1]};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            if (addr_hit(shift_q[7:1], strap_q)) begin
                                sda_oe_q  <= 1'b1; // [R8]
                                pair_hi_q <= 1'b0; // [R3]
                                state_q   <= `PXE_ST_AACK;
                            end else begin
                                state_q <= `PXE_ST_IDLE; // [R10]
                            end
                        end
                    end
                    `PXE_ST_AACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (shift_q[0]) begin
                                // Read: sample both ports as one pair
                                snap_q    <= pin_q;
                                sda_oe_q  <= ~pin_q[7];
                                shift_q   <= {pin_q[6:0], 1'b1};
                                state_q   <= `PXE_ST_RDATA;
                            end else begin
                                sda_oe_q <= 1'b0;
                                state_q  <= `PXE_ST_WDATA;
                            end
                        end
                    end
                    `PXE_ST_WDATA: begin
                        if (scl_rise) begin
                            shift_q   <= {shift_q[6:0], sda_s_q[1]};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            sda_oe_q <= 1'b1; // [R8]
                            state_q  <= `PXE_ST_WACK;
                        end
                    end
                    `PXE_ST_WACK: begin
                        if (scl_fall) begin
                            sda_oe_q  <= 1'b0;
                            bit_cnt_q <= 4'h0;
                            state_q   <= `PXE_ST_WDATA;
                            pair_hi_q <= ~pair_hi_q;
                            if (pair_hi_q) begin
                                // Whole pair acked: update port together
                                low_port_lines_q  <= low_hold_q; // [R7]
                                high_port_lines_q <= shift_q; // [R7] [R3]
                                clr_int_q         <= 1'b1; // [R9]
                            end else begin
                                low_hold_q <= shift_q; // [R7]
                            end
                        end
                    end
                    `PXE_ST_RDATA: begin
                        if (scl_fall) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'h7) begin
                                sda_oe_q <= 1'b0; // Release for master ack
                                state_q  <= `PXE_ST_RACK;
                            end else begin
                                // Drive low for 0 only (open drain)
                                sda_oe_q <= ~shift_q[7];
                                shift_q  <= {shift_q[6:0], 1'b1};
                            end
                        end
                    end
                    `PXE_ST_RACK: begin
                        if (scl_rise) begin
                            if (pair_hi_q) begin
                                clr_int_q <= 1'b1; // [R9]
                            end
                            if (sda_s_q[1]) begin
                                state_q <= `PXE_ST_IDLE; // Nack ends read
                            end
                        end else if (scl_fall) begin
                            // Low byte first, then high byte [R7] [R3]
                            bit_cnt_q <= 4'h0;
                            pair_hi_q <= ~pair_hi_q;
                            state_q   <= `PXE_ST_RDATA;
                            if (pair_hi_q) begin
                                snap_q   <= pin_q;
                                sda_oe_q <= ~pin_q[7];
                                shift_q  <= {pin_q[6:0], 1'b1};
                            end else begin
                                sda_oe_q <= ~snap_q[15];
                                shift_q  <= {snap_q[14:8], 1'b1};
                            end
                        end
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ********************************************
    // Interrupt
    // ********************************************
    reg  [15:0] ref_q;          // Port value at last clear

    // Differs from reference: assert; matching again or access clears.
    // Ref is stored one cycle after a port write, before lines driven low by us read back low in pin_q.
    always @(posedge clk) begin
        if (srst) begin
            ref_q   <= `PXE_PORT_RESET;
            int_n_q <= 1'b1;
        end else begin
            if (clr_int_q) begin
                ref_q <= pin_q; // [R9]
            end
            int_n_q <= ~((pin_q != ref_q) && !clr_int_q); // [R9]
        end
    end

endmodule // pxe_top
